// ===== logic/gcmli_pkg.sv
// shared constants and types for the general-purpose pin and clock mask unit
`default_nettype none

package gcmli_pkg;

    // ------------------------------------------------------------------
    // configuration locations (byte offsets in device-specific space)
    // ------------------------------------------------------------------
    localparam logic [7:0]  OFF_PIN_OUTPUT_VALUE      = 8'h64;
    localparam logic [7:0]  OFF_PIN_DIRECTION_CONTROL = 8'h68;
    localparam logic [7:0]  OFF_PIN_INPUT_VALUE       = 8'h6C;
    localparam logic [7:0]  OFF_SEC_CLK_DISABLE_MASK  = 8'h70;

    // ------------------------------------------------------------------
    // field layout
    // ------------------------------------------------------------------
    localparam int          PIN_N      = 4;
    localparam int          SET_LSB    = 0;
    localparam int          CLR_LSB    = 8;
    localparam int          MASK_W     = 16;
    localparam int          SCLK_N     = 10;
    localparam int          SLOT_N     = 4;
    localparam int          DEV_LSB    = 8;
    localparam int          DEV_N      = 5;
    localparam int          OWN_BIT    = 13;
    localparam int          PIN_SCLK   = 0;
    localparam int          PIN_SEL    = 2;
    localparam int          PIN_HALT   = 3;

    // ------------------------------------------------------------------
    // reset values and loader pin enables
    // ------------------------------------------------------------------
    localparam logic [3:0]  RST_OUT_VAL  = 4'h0;
    localparam logic [3:0]  RST_DIR      = 4'h0;
    localparam logic [15:0] RST_MASK     = 16'h0000;
    localparam logic [3:0]  LOAD_OE      = 4'h5;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int          MCLK_PERIOD_NS  = 50;
    localparam int          SCLK_HALF_NS    = 200;
    localparam int          SCLK_HALF66_NS  = 400;
    localparam logic [3:0]  SCLK_HALF_CYC   = 4'((SCLK_HALF_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS);
    localparam logic [3:0]  SCLK_HALF66_CYC = 4'((SCLK_HALF66_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS);
    localparam logic [4:0]  SHIFT_BITS      = 5'd16;

    // ------------------------------------------------------------------
    // mask loader states
    // ------------------------------------------------------------------
    typedef enum logic [1:0]
    {
        GCMLI_LD_LOAD,
        GCMLI_LD_SHIFT,
        GCMLI_LD_DONE
    } gcmli_ld_t;

endpackage

`default_nettype wire

// ===== logic/gcmli_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none

module gcmli_sync
#(
    parameter int W = 1
)
(
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    input  wire logic [W-1:0] d_i,
    output var  logic [W-1:0] q_o
);

    logic [W-1:0] meta_r;

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            meta_r <= '0;
            q_o    <= '0;
        end
        else
        begin
            meta_r <= d_i;
            q_o    <= meta_r;
        end
    end

endmodule

`default_nettype wire

// ===== logic/gcmli_top.sv
// general-purpose pins, secondary clock mask loader and live insertion halt
`timescale 1ns/1ps
`default_nettype none

module gcmli_top
    import gcmli_pkg::*;
(
    input  wire logic        mclk_i,
    input  wire logic        resetn_i,
    input  wire logic        cfg_wr_i,
    input  wire logic        cfg_rd_i,
    input  wire logic [7:0]  cfg_addr_i,
    input  wire logic [31:0] cfg_wdata_i,
    input  wire logic [3:0]  cfg_be_i,
    input  wire logic [3:0]  gpio_in_i,
    input  wire logic        mask_serial_i,
    input  wire logic        m66_i,
    input  wire logic        sec_reset_bit_i,
    input  wire logic        live_mode_i,
    input  wire logic        cmd_io_en_i,
    input  wire logic        cmd_mem_en_i,
    input  wire logic        cmd_master_en_i,
    output var  logic [31:0] cfg_rdata_o,
    output var  logic        cfg_rvalid_o,
    output var  logic [3:0]  gpio_out_o,
    output var  logic [3:0]  gpio_oe_o,
    output var  logic        srst_n_o,
    output var  logic [9:0]  sclk_en_o,
    output var  logic        mask_done_o,
    output var  logic        io_en_o,
    output var  logic        mem_en_o,
    output var  logic        master_en_o,
    output var  logic        halted_o,
    output var  logic        dcmpl_block_o,
    output var  logic        cfg_accept_o
);

    // ------------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------------
    logic rst_meta_r;
    logic rst_n;

    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            rst_meta_r <= 1'b0;
            rst_n      <= 1'b0;
        end
        else
        begin
            rst_meta_r <= 1'b1;
            rst_n      <= rst_meta_r;
        end
    end

    // ------------------------------------------------------------------
    // pin input synchronisers
    // ------------------------------------------------------------------
    logic [5:0] pins_sync;
    logic [3:0] gpio_lvl;
    logic       serial_lvl;
    logic       m66_lvl;

    gcmli_sync #(.W(6)) u_sync
    (
        .clk_i   (mclk_i),
        .rst_n_i (rst_n),
        .d_i     ({m66_i, mask_serial_i, gpio_in_i}),
        .q_o     (pins_sync)
    );

    assign gpio_lvl   = pins_sync[3:0];
    assign serial_lvl = pins_sync[4];
    assign m66_lvl    = pins_sync[5];

    // ------------------------------------------------------------------
    // shift clock divider
    // ------------------------------------------------------------------
    logic [3:0] div_r;
    logic [3:0] div_nxt;
    logic [3:0] half_cyc;
    logic       tick;

    assign half_cyc = m66_lvl ? SCLK_HALF66_CYC : SCLK_HALF_CYC;
    assign tick     = (div_r == half_cyc - 4'h1);

    always_comb
    begin
        div_nxt = tick ? 4'h0 : div_r + 4'h1;
    end

    always_ff @(posedge mclk_i or negedge rst_n)
    begin
        if (!rst_n)
            div_r <= 4'h0;
        else
            div_r <= div_nxt;
    end

    // ------------------------------------------------------------------
    // mask loader
    // ------------------------------------------------------------------
    gcmli_ld_t   ld_r;
    gcmli_ld_t   ld_nxt;
    logic        sclk_r;
    logic        sclk_nxt;
    logic        sel_r;
    logic        sel_nxt;
    logic [4:0]  cnt_r;
    logic [4:0]  cnt_nxt;
    logic [15:0] mask_r;
    logic [15:0] mask_nxt;
    logic        mask_wr;
    logic        loading;

    // loader starts at once after release of primary reset
    assign loading = (ld_r != GCMLI_LD_DONE);
    assign mask_wr = cfg_wr_i && !loading && (cfg_addr_i == OFF_SEC_CLK_DISABLE_MASK);

    always_comb
    begin
        ld_nxt   = ld_r;
        sclk_nxt = sclk_r;
        sel_nxt  = sel_r;
        cnt_nxt  = cnt_r;
        mask_nxt = mask_r;
        unique case (ld_r)
            GCMLI_LD_LOAD:
            begin
                // board register loads on the rising edge while select is low
                if (tick)
                begin
                    if (!sclk_r)
                        sclk_nxt = 1'b1;
                    else
                    begin
                        sclk_nxt = 1'b0;
                        sel_nxt  = 1'b1;
                        ld_nxt   = GCMLI_LD_SHIFT;
                    end
                end
            end
            GCMLI_LD_SHIFT:
            begin
                if (tick)
                begin
                    if (!sclk_r)
                    begin
                        // capture the bit present, then shift the next one out
                        mask_nxt = {mask_r[14:0], serial_lvl};
                        cnt_nxt  = cnt_r + 5'd1;
                        sclk_nxt = 1'b1;
                    end
                    else
                    begin
                        sclk_nxt = 1'b0;
                        if (cnt_r == SHIFT_BITS)
                            ld_nxt = GCMLI_LD_DONE;
                    end
                end
            end
            GCMLI_LD_DONE:
            begin
                sel_nxt = 1'b0;
                if (mask_wr)
                begin
                    if (cfg_be_i[0])
                        mask_nxt[7:0] = cfg_wdata_i[7:0];
                    if (cfg_be_i[1])
                        mask_nxt[15:8] = cfg_wdata_i[15:8];
                end
            end
        endcase
    end

    always_ff @(posedge mclk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ld_r   <= GCMLI_LD_LOAD;
            sclk_r <= 1'b0;
            sel_r  <= 1'b0;
            cnt_r  <= 5'd0;
            mask_r <= RST_MASK;
        end
        else
        begin
            ld_r   <= ld_nxt;
            sclk_r <= sclk_nxt;
            sel_r  <= sel_nxt;
            cnt_r  <= cnt_nxt;
            mask_r <= mask_nxt;
        end
    end

    // ------------------------------------------------------------------
    // pin control registers
    // ------------------------------------------------------------------
    logic [3:0] out_r;
    logic [3:0] out_nxt;
    logic [3:0] dir_r;
    logic [3:0] dir_nxt;
    logic       wr_out;
    logic       wr_dir;

    assign wr_out = cfg_wr_i && (cfg_addr_i == OFF_PIN_OUTPUT_VALUE);
    assign wr_dir = cfg_wr_i && (cfg_addr_i == OFF_PIN_DIRECTION_CONTROL);

    always_comb
    begin
        out_nxt = out_r;
        dir_nxt = dir_r;
        // set wins over clear when both bits are written together
        if (wr_out && cfg_be_i[1])
            out_nxt = out_nxt & ~cfg_wdata_i[CLR_LSB +: PIN_N];
        if (wr_out && cfg_be_i[0])
            out_nxt = out_nxt | cfg_wdata_i[SET_LSB +: PIN_N];
        if (wr_dir && cfg_be_i[1])
            dir_nxt = dir_nxt & ~cfg_wdata_i[CLR_LSB +: PIN_N];
        if (wr_dir && cfg_be_i[0])
            dir_nxt = dir_nxt | cfg_wdata_i[SET_LSB +: PIN_N];
    end

    always_ff @(posedge mclk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            out_r <= RST_OUT_VAL;
            dir_r <= RST_DIR;
        end
        else
        begin
            out_r <= out_nxt;
            dir_r <= dir_nxt;
        end
    end

    // ------------------------------------------------------------------
    // configuration read port
    // ------------------------------------------------------------------
    logic [31:0] rdata_nxt;

    always_comb
    begin
        rdata_nxt = 32'h0000_0000;
        unique case (cfg_addr_i)
            OFF_PIN_OUTPUT_VALUE:
                rdata_nxt = {20'h00000, out_r, 4'h0, out_r};
            OFF_PIN_DIRECTION_CONTROL:
                rdata_nxt = {20'h00000, dir_r, 4'h0, dir_r};
            OFF_PIN_INPUT_VALUE:
                rdata_nxt = {28'h0000000, gpio_lvl};
            OFF_SEC_CLK_DISABLE_MASK:
                rdata_nxt = {16'h0000, mask_r};
            default:
                rdata_nxt = 32'h0000_0000;
        endcase
        if (!cfg_rd_i)
            rdata_nxt = 32'h0000_0000;
    end

    always_ff @(posedge mclk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cfg_rdata_o  <= 32'h0000_0000;
            cfg_rvalid_o <= 1'b0;
        end
        else
        begin
            cfg_rdata_o  <= rdata_nxt;
            cfg_rvalid_o <= cfg_rd_i;
        end
    end

    // ------------------------------------------------------------------
    // clock enables from the mask
    // ------------------------------------------------------------------
    logic [9:0] sclk_en_nxt;

    genvar gi;
    generate
        for (gi = 0; gi < SLOT_N; gi++)
        begin : g_slot
            assign sclk_en_nxt[gi] = !loading ? ~(mask_r[2*gi] & mask_r[2*gi+1]) : 1'b1;
        end
        for (gi = 0; gi < DEV_N; gi++)
        begin : g_dev
            assign sclk_en_nxt[SLOT_N+gi] = !loading ? ~mask_r[DEV_LSB+gi] : 1'b1;
        end
    endgenerate

    // reserved bits 14 and 15 feed nothing
    assign sclk_en_nxt[SCLK_N-1] = !loading ? ~mask_r[OWN_BIT] : 1'b1;

    // ------------------------------------------------------------------
    // pins, secondary reset and live insertion
    // ------------------------------------------------------------------
    logic [3:0] pin_out_nxt;
    logic [3:0] pin_oe_nxt;
    logic       halt_nxt;

    always_comb
    begin
        pin_out_nxt = out_r;
        pin_oe_nxt  = dir_r;
        if (loading)
        begin
            pin_out_nxt           = 4'h0;
            pin_out_nxt[PIN_SCLK] = sclk_r;
            pin_out_nxt[PIN_SEL]  = sel_r;
            pin_oe_nxt            = LOAD_OE;
        end
        halt_nxt = live_mode_i && !dir_r[PIN_HALT] && gpio_lvl[PIN_HALT];
    end

    always_ff @(posedge mclk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            gpio_out_o    <= 4'h0;
            gpio_oe_o     <= RST_DIR;
            srst_n_o      <= 1'b0;
            sclk_en_o     <= '1;
            mask_done_o   <= 1'b0;
            io_en_o       <= 1'b0;
            mem_en_o      <= 1'b0;
            master_en_o   <= 1'b0;
            halted_o      <= 1'b0;
            dcmpl_block_o <= 1'b0;
            cfg_accept_o  <= 1'b0;
        end
        else
        begin
            gpio_out_o    <= pin_out_nxt;
            gpio_oe_o     <= pin_oe_nxt;
            srst_n_o      <= !loading && !sec_reset_bit_i;
            sclk_en_o     <= sclk_en_nxt;
            mask_done_o   <= !loading;
            io_en_o       <= cmd_io_en_i && !halt_nxt;
            mem_en_o      <= cmd_mem_en_i && !halt_nxt;
            master_en_o   <= cmd_master_en_i && !halt_nxt;
            halted_o      <= halt_nxt;
            dcmpl_block_o <= halt_nxt;
            cfg_accept_o  <= 1'b1;
        end
    end

endmodule

`default_nettype wire

// ===== tb/gcmli_checker.sv
// timing checks on the pin and clock mask unit ports
`timescale 1ns/1ps
`default_nettype none

module gcmli_checker
    import gcmli_pkg::*;
(
    input wire logic        mclk_i,
    input wire logic        resetn_i,
    input wire logic        cfg_wr_i,
    input wire logic        cfg_rd_i,
    input wire logic [7:0]  cfg_addr_i,
    input wire logic [31:0] cfg_wdata_i,
    input wire logic [3:0]  cfg_be_i,
    input wire logic        sec_reset_bit_i,
    input wire logic        cfg_rvalid_o,
    input wire logic [3:0]  gpio_out_o,
    input wire logic [3:0]  gpio_oe_o,
    input wire logic        srst_n_o,
    input wire logic [9:0]  sclk_en_o,
    input wire logic        mask_done_o,
    input wire logic        io_en_o,
    input wire logic        mem_en_o,
    input wire logic        master_en_o,
    input wire logic        halted_o,
    input wire logic        dcmpl_block_o,
    input wire logic        cfg_accept_o
);
    logic [4:0] rise_r;
    logic [4:0] rise_nxt;
    logic       sck_r;
    logic       sck_nxt;
    logic       mwr;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);
    // ------------------------------------------------------------
    // shift clock rises counted while loading
    // ------------------------------------------------------------
    assign mwr = cfg_wr_i && cfg_addr_i == OFF_SEC_CLK_DISABLE_MASK && cfg_be_i == 4'h3 && mask_done_o;
    always_comb
    begin
        sck_nxt  = gpio_out_o[0] & gpio_oe_o[0];
        rise_nxt = (!mask_done_o && sck_nxt && !sck_r) ? rise_r + 5'h1 : rise_r;
    end
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            rise_r <= 5'h0;
            sck_r  <= 1'b0;
        end
        else
        begin
            rise_r <= rise_nxt;
            sck_r  <= sck_nxt;
        end
    end
    a_halt_masks_en: assert property (halted_o |-> !io_en_o && !mem_en_o && !master_en_o)
        else $error("enables not masked");
    a_halt_keeps_cfg: assert property (halted_o |-> cfg_accept_o)
        else $error("config refused while halted");
    a_dcmpl_held_back: assert property (dcmpl_block_o == halted_o)
        else $error("completion hold wrong");
    a_read_answer: assert property (cfg_rd_i |=> cfg_rvalid_o)
        else $error("read not answered");
    a_srst_while_load: assert property (!mask_done_o |-> !srst_n_o)
        else $error("secondary reset released early");
    a_load_pin_use: assert property ((!mask_done_o && |gpio_oe_o) |-> gpio_oe_o == 4'h5)
        else $error("wrong pins driven while loading");
    a_select_stays_high: assert property ((!mask_done_o && gpio_oe_o[2]) |-> !$fell(gpio_out_o[2]))
        else $error("select fell during shift");
    a_shift_count: assert property ($rose(mask_done_o) |-> rise_r == 5'h11)
        else $error("wrong shift clock count");
    a_srst_release: assert property (($rose(mask_done_o) && !sec_reset_bit_i) |-> ##[0:1] srst_n_o)
        else $error("secondary reset not released");
    a_slot_pair: assert property (mwr |-> ##2 sclk_en_o[0] == !(&$past(cfg_wdata_i[1:0], 2)))
        else $error("slot clock wrong");
    a_dev_clocks: assert property (mwr |-> ##2 sclk_en_o[8:4] == ~$past(cfg_wdata_i[12:8], 2))
        else $error("device clocks wrong");
    a_own_clock: assert property (mwr |-> ##2 sclk_en_o[9] == !$past(cfg_wdata_i[13], 2))
        else $error("own clock wrong");
    c_load_done: cover property ($rose(mask_done_o));
    c_halt: cover property ($rose(halted_o));
    c_mask_write: cover property (mwr);
endmodule

bind gcmli_top gcmli_checker u_chk (.*);

`default_nettype wire

// ===== tb/gcmli_shift_model.sv
// board parallel-load shift register feeding the serial mask input
`timescale 1ns/1ps
`default_nettype none

module gcmli_shift_model
(
    input  wire logic        mclk_i,
    input  wire logic [3:0]  pin_out_i,
    input  wire logic [3:0]  pin_oe_i,
    input  wire logic [15:0] par_i,
    output var  logic        ser_o
);
    logic [15:0] sr_r;
    logic        junk_r = 1'b0;
    // ------------------------------------------------------------
    // load while select low, shift while high, on clock rise
    // ------------------------------------------------------------
    always @(posedge pin_out_i[0])
    begin
        if (pin_oe_i[0] && pin_oe_i[2])
            sr_r <= pin_out_i[2] ? {sr_r[14:0], ~sr_r[15]} : par_i;
    end
    // an unselected register leaves the line wandering
    always @(posedge mclk_i)
        junk_r <= ~junk_r;
    assign ser_o = pin_oe_i[2] ? sr_r[15] : junk_r;
endmodule

`default_nettype wire

// ===== tb/gcmli_tb.sv
// self-checking bench for the pin and clock mask unit
`timescale 1ns/1ps
`default_nettype none

module gcmli_tb;
    import gcmli_pkg::*;
    logic        mclk_i = 1'b0;
    logic        resetn_i = 1'b0;
    logic        cfg_wr_i = 1'b0;
    logic        cfg_rd_i = 1'b0;
    logic [7:0]  cfg_addr_i = 8'h00;
    logic [31:0] cfg_wdata_i = 32'h0;
    logic [3:0]  cfg_be_i = 4'h0;
    logic        m66_i = 1'b0;
    logic        sec_reset_bit_i = 1'b0;
    logic        live_mode_i = 1'b0;
    logic        cmd_io_en_i = 1'b1;
    logic        cmd_mem_en_i = 1'b1;
    logic        cmd_master_en_i = 1'b1;
    logic [3:0]  ext_pins = 4'hE;
    logic [15:0] par_mask = 16'h0;
    logic [3:0]  gpio_in_i;
    logic        mask_serial_i;
    logic [31:0] cfg_rdata_o;
    logic [3:0]  gpio_out_o;
    logic [3:0]  gpio_oe_o;
    logic [9:0]  sclk_en_o;
    logic        cfg_rvalid_o, srst_n_o, mask_done_o, io_en_o, mem_en_o, master_en_o;
    logic        halted_o, dcmpl_block_o, cfg_accept_o;
    int          n_fail = 0;
    int          n_tests = 0;
    int          cyc = 0;

    gcmli_top dut (.*);
    gcmli_shift_model u_sr (.mclk_i(mclk_i), .pin_out_i(gpio_out_o), .pin_oe_i(gpio_oe_o),
                            .par_i(par_mask), .ser_o(mask_serial_i));
    assign gpio_in_i = (gpio_oe_o & gpio_out_o) | (~gpio_oe_o & ext_pins);

    // ------------------------------------------------------------
    // clock, watchdog and shared tasks
    // ------------------------------------------------------------
    always #25 mclk_i = ~mclk_i;
    always @(posedge mclk_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_fail++;
            complete_run();
        end
    end
    task automatic complete_run();
        if (n_fail == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] exp, input logic [31:0] act, input string msg);
        n_tests++;
        if (act !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: %s got %h want %h", $time, msg, act, exp);
        end
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(negedge mclk_i);
    endtask
    task automatic cfg_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
        @(negedge mclk_i);
        cfg_wr_i = 1'b1;
        cfg_addr_i = a;
        cfg_wdata_i = d;
        cfg_be_i = be;
        @(negedge mclk_i);
        cfg_wr_i = 1'b0;
    endtask
    task automatic cfg_rd(input logic [7:0] a, input logic [31:0] exp, input string msg);
        @(negedge mclk_i);
        cfg_rd_i = 1'b1;
        cfg_addr_i = a;
        @(negedge mclk_i);
        cfg_rd_i = 1'b0;
        chk(1'b1, cfg_rvalid_o, "read valid");
        chk(exp, cfg_rdata_o, msg);
    endtask
    function automatic logic [9:0] exp_clk(input logic [15:0] m);
        logic [9:0] e;
        for (int i = 0; i < 4; i++)
            e[i] = ~(m[2*i] & m[2*i+1]);
        e[8:4] = ~m[12:8];
        e[9] = ~m[13];
        return e;
    endfunction

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_load(input logic [15:0] m, input logic fast, input logic srb);
        int k;
        @(negedge mclk_i);
        resetn_i = 1'b0;
        par_mask = m;
        m66_i = fast;
        sec_reset_bit_i = srb;
        wait_cyc(4);
        resetn_i = 1'b1;
        wait_cyc(20);
        chk(1'b0, srst_n_o, "reset held while loading");
        chk(4'h5, gpio_oe_o, "loader pins");
        k = 0;
        while (mask_done_o !== 1'b1 && k < 800)
        begin
            wait_cyc(1);
            k++;
        end
        chk(1'b1, mask_done_o, "mask load finished");
        wait_cyc(2);
        chk(!srb, srst_n_o, "reset after load");
        chk(4'h0, gpio_oe_o, "pins released");
        cfg_rd(OFF_SEC_CLK_DISABLE_MASK, {16'h0, m}, "loaded mask");
        chk(exp_clk(m), sclk_en_o, "clock enables");
        cfg_rd(OFF_PIN_OUTPUT_VALUE, 32'h0, "output reset");
        sec_reset_bit_i = 1'b0;
        wait_cyc(3);
        chk(1'b1, srst_n_o, "reset released");
    endtask
    task automatic t_gpio();
        cfg_rd(OFF_PIN_INPUT_VALUE, 32'hE, "pin levels");
        cfg_wr(OFF_PIN_OUTPUT_VALUE, 32'h3, 4'h1);
        wait_cyc(2);
        chk(4'h0, gpio_oe_o, "no drive unless enabled");
        cfg_rd(OFF_PIN_OUTPUT_VALUE, 32'h303, "output value");
        cfg_wr(OFF_PIN_DIRECTION_CONTROL, 32'h5, 4'h1);
        cfg_wr(OFF_PIN_DIRECTION_CONTROL, 32'h0, 4'h3);
        wait_cyc(4);
        chk(4'h5, gpio_oe_o, "direction set");
        chk(4'h1, gpio_out_o & gpio_oe_o, "driven values");
        cfg_rd(OFF_PIN_INPUT_VALUE, 32'hB, "mixed levels");
        cfg_wr(OFF_PIN_DIRECTION_CONTROL, 32'h100, 4'h2);
        cfg_wr(OFF_PIN_OUTPUT_VALUE, 32'h109, 4'h3);
        cfg_wr(8'h10, 32'hFFFF_FFFF, 4'hF);
        wait_cyc(2);
        chk(4'h4, gpio_oe_o, "direction cleared");
        cfg_rd(OFF_PIN_OUTPUT_VALUE, 32'hB0B, "set and clear");
        cfg_rd(8'h10, 32'h0, "unmapped read");
    endtask
    task automatic t_maskwr();
        cfg_wr(OFF_SEC_CLK_DISABLE_MASK, 32'h1C35, 4'h3);
        wait_cyc(2);
        chk(exp_clk(16'h1C35), sclk_en_o, "written mask on clocks");
        cfg_wr(OFF_SEC_CLK_DISABLE_MASK, 32'hFFFF, 4'h2);
        cfg_rd(OFF_SEC_CLK_DISABLE_MASK, 32'hFF35, "mask readback");
    endtask
    task automatic t_live();
        cfg_wr(OFF_PIN_DIRECTION_CONTROL, 32'hF00, 4'h2);
        wait_cyc(5);
        chk(1'b0, halted_o, "no halt outside mode");
        live_mode_i = 1'b1;
        wait_cyc(5);
        chk(4'h8, {halted_o, io_en_o, mem_en_o, master_en_o}, "halted");
        chk(2'h3, {dcmpl_block_o, cfg_accept_o}, "halt side flags");
        cfg_rd(OFF_PIN_INPUT_VALUE, 32'hE, "config while halted");
        cmd_mem_en_i = 1'b0;
        ext_pins = 4'h6;
        wait_cyc(5);
        chk(4'h5, {halted_o, io_en_o, mem_en_o, master_en_o}, "enables restored");
        ext_pins = 4'hE;
        cfg_wr(OFF_PIN_DIRECTION_CONTROL, 32'h8, 4'h1);
        wait_cyc(5);
        chk(1'b0, halted_o, "driven pin does not halt");
    endtask

    initial
    begin
        t_load(16'h2B1E, 1'b0, 1'b0);
        t_load(16'h0000, 1'b0, 1'b0);
        t_load(16'hFFFF, 1'b1, 1'b1);
        t_gpio();
        t_maskwr();
        t_live();
        complete_run();
    end
endmodule

`default_nettype wire
